// file: src/system_clock_source_select.sv
`timescale 1ns/10ps
`default_nettype none
module system_clock_source_select
  import clock_select_pkg::*;
#(
  parameter logic [7:0] TRIM_RESET = RESET_INTERNAL_OSC_TRIM,
  parameter int CRYSTAL_EDGES = CRYSTAL_SETTLE_EDGES,
  parameter int SWITCH_TIMEOUT = SWITCH_TIMEOUT_CYCLES
) (
  input wire logic core_clk,
  input wire logic arst_n,
  // special function register port
  input wire logic [7:0] sfr_addr,
  input wire logic [7:0] sfr_wdata,
  input wire logic sfr_write,
  input wire logic sfr_read,
  output logic [7:0] sfr_rdata,
  // oscillator pins and PLL status
  input wire logic crystal_pin_a,
  input wire logic pll_tick,
  input wire logic pll_locked,
  // oscillator controls
  output logic internal_osc_enable,
  output logic [7:0] osc_trim,
  output logic [2:0] external_mode_sel,
  output logic [2:0] external_freq_ctrl,
  // clock enables and the active source code
  output logic system_clock,
  output logic external_tick,
  output logic clock_out_tick,
  output logic [1:0] active_source
);
  // register fields
  logic [1:0] internal_divide_sel; // internal divide code
  logic [1:0] clock_source_sel; // requested source
  logic [1:0] clock_out_divide; // port pin divide code
  logic internal_osc_ready; // internal oscillator at frequency
  logic crystal_valid; // crystal settled
  logic [2:0] int_settle; // internal settle counter
  logic [10:0] xtal_edges; // crystal edge counter
  // pin synchroniser and edge detect
  logic pin_meta; // first stage, read only by pin_sync
  logic pin_sync; // second stage
  logic pin_prev; // delayed copy for edge detect
  logic ext_raw_tick; // rising edge of external clock
  logic [1:0] ext_ratio; // external divide by 2 stage
  logic ext_tick_div; // external tick after mode divide
  logic int_tick_div; // scaled internal tick
  logic sys_tick; // next system clock pulse
  logic out_tick_div; // divided system tick
  logic old_tick; // tick of the source now in use
  logic [8:0] switch_wait; // cycles since a change was requested
  logic ext_mode_on; // external circuit running
  logic is_crystal; // crystal modes

  assign ext_mode_on = external_mode_sel[2:1] != 2'b00;
  assign is_crystal = external_mode_sel[2:1] == 2'b11;

  // two flip-flops before the external pin is used
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      pin_meta <= 1'b0;
      pin_sync <= 1'b0;
      pin_prev <= 1'b0;
    end else begin
      pin_meta <= crystal_pin_a;
      pin_sync <= pin_meta;
      pin_prev <= pin_sync;
    end
  end

  // external circuit off in modes 00x
  assign ext_raw_tick = ext_mode_on && pin_sync && !pin_prev;

  // divide by 2 stage for RC and the odd CMOS and crystal codes
  always_comb begin
    if (external_mode_sel[2:1] == 2'b10) begin
      ext_ratio = 2'b01;
    end else begin
      ext_ratio = {1'b0, external_mode_sel[0]};
    end
  end

  // external oscillator after its mode divider
  tick_divider u_ext_div (
    .core_clk(core_clk),
    .arst_n(arst_n),
    .tick_in(ext_raw_tick),
    .ratio_log2(ext_ratio),
    .tick_out(ext_tick_div)
  );

  // code 00 is /8, code 11 is /1
  tick_divider u_int_div (
    .core_clk(core_clk),
    .arst_n(arst_n),
    .tick_in(internal_osc_enable && internal_osc_ready),
    .ratio_log2(2'b11 - internal_divide_sel),
    .tick_out(int_tick_div)
  );

  // tick of the source that drives the system clock
  always_comb begin
    unique case (active_source)
      SRC_INTERNAL: old_tick = int_tick_div;
      SRC_EXTERNAL: old_tick = ext_tick_div;
      SRC_PLL: old_tick = pll_tick;
      SRC_RESERVED: old_tick = 1'b0;
    endcase
  end
  assign sys_tick = old_tick;

  // code 00 is /1, code 11 is /8
  tick_divider u_out_div (
    .core_clk(core_clk),
    .arst_n(arst_n),
    .tick_in(sys_tick),
    .ratio_log2(clock_out_divide),
    .tick_out(out_tick_div)
  );

  // register writes
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      internal_osc_enable <= RESET_INTERNAL_OSC_CONTROL[BIT_INTERNAL_OSC_ENABLE];
      internal_divide_sel <= RESET_INTERNAL_OSC_CONTROL[1:0];
      osc_trim <= TRIM_RESET;
      external_mode_sel <= RESET_EXTERNAL_OSC_CONTROL[6:4];
      external_freq_ctrl <= RESET_EXTERNAL_OSC_CONTROL[2:0];
      clock_out_divide <= RESET_SYSTEM_CLOCK_SELECT[5:4];
      clock_source_sel <= RESET_SYSTEM_CLOCK_SELECT[1:0];
    end else if (sfr_write) begin
      unique case (sfr_addr)
        ADDR_INTERNAL_OSC_CONTROL: begin
          // enable and divide in one write
          internal_osc_enable <= sfr_wdata[BIT_INTERNAL_OSC_ENABLE];
          internal_divide_sel <= sfr_wdata[LSB_INTERNAL_DIVIDE_SEL +: 2];
        end
        ADDR_INTERNAL_OSC_TRIM: begin
          osc_trim <= sfr_wdata;
        end
        ADDR_EXTERNAL_OSC_CONTROL: begin
          // bit 3 and bit 7 are not stored
          external_mode_sel <= sfr_wdata[LSB_EXTERNAL_MODE_SEL +: 3];
          external_freq_ctrl <= sfr_wdata[LSB_EXTERNAL_FREQ_CTRL +: 3];
        end
        ADDR_SYSTEM_CLOCK_SELECT: begin
          clock_out_divide <= sfr_wdata[LSB_CLOCK_OUT_DIVIDE +: 2];
          clock_source_sel <= sfr_wdata[LSB_CLOCK_SOURCE_SEL +: 2];
        end
        default: begin
          // other addresses belong to other blocks
        end
      endcase
    end
  end

  // internal oscillator ready after a short settle
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      int_settle <= 3'h0;
      internal_osc_ready <= RESET_INTERNAL_OSC_CONTROL[BIT_INTERNAL_OSC_READY];
    end else if (!internal_osc_enable) begin
      int_settle <= 3'h0;
      internal_osc_ready <= 1'b0;
    end else if (!internal_osc_ready) begin
      if (int_settle == 3'(INT_OSC_SETTLE_CYCLES - 1)) begin
        internal_osc_ready <= 1'b1;
      end else begin
        int_settle <= int_settle + 3'h1;
      end
    end
  end

  // crystal valid after enough edges counted while in a crystal mode
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      xtal_edges <= 11'h000;
      crystal_valid <= 1'b0;
    end else if (!is_crystal) begin
      // cleared whenever the crystal is unused
      xtal_edges <= 11'h000;
      crystal_valid <= 1'b0;
    end else if (ext_raw_tick && !crystal_valid) begin
      if (xtal_edges == 11'(CRYSTAL_EDGES - 1)) begin
        crystal_valid <= 1'b1;
      end else begin
        xtal_edges <= xtal_edges + 11'h001;
      end
    end
  end

  // source change waits for the old source to finish a period
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      // internal drives the system clock from reset
      active_source <= SRC_INTERNAL;
      switch_wait <= 9'h000;
    end else if (clock_source_sel == active_source || clock_source_sel == SRC_RESERVED) begin
      // reserved code keeps the current source
      switch_wait <= 9'h000;
    end else if (old_tick || switch_wait == 9'(SWITCH_TIMEOUT - 1)) begin
      // swap right after a whole old period
      // run-time switch to the requested source
      active_source <= clock_source_sel;
      switch_wait <= 9'h000;
    end else begin
      // timeout covers an old source that has stopped
      switch_wait <= switch_wait + 9'h001;
    end
  end

  // registered clock enables
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      system_clock <= 1'b0;
      external_tick <= 1'b0;
      clock_out_tick <= 1'b0;
    end else begin
      system_clock <= sys_tick;
      // external clock for timers regardless of source
      external_tick <= ext_tick_div;
      // divided copy for the port pin
      clock_out_tick <= out_tick_div;
    end
  end

  // register reads, one cycle after the strobe
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      sfr_rdata <= 8'h00;
    end else if (sfr_read) begin
      unique case (sfr_addr)
        ADDR_INTERNAL_OSC_CONTROL: begin
          sfr_rdata <= {internal_osc_enable, internal_osc_ready, 4'h0, internal_divide_sel};
        end
        ADDR_INTERNAL_OSC_TRIM: begin
          sfr_rdata <= osc_trim;
        end
        ADDR_EXTERNAL_OSC_CONTROL: begin
          sfr_rdata <= {crystal_valid, external_mode_sel, 1'b0, external_freq_ctrl};
        end
        ADDR_SYSTEM_CLOCK_SELECT: begin
          // lock flag seen in bit 7 of this view
          sfr_rdata <= {pll_locked, 1'b0, clock_out_divide, 2'b00, clock_source_sel};
        end
        default: begin
          sfr_rdata <= 8'h00;
        end
      endcase
    end
  end
endmodule : system_clock_source_select
`default_nettype wire

// file: include/clock_select_pkg.sv
package clock_select_pkg;
  // register addresses on the special function register port
  localparam logic [7:0] ADDR_INTERNAL_OSC_CONTROL = 8'h8A;
  localparam logic [7:0] ADDR_INTERNAL_OSC_TRIM = 8'h8B;
  localparam logic [7:0] ADDR_EXTERNAL_OSC_CONTROL = 8'h8C;
  localparam logic [7:0] ADDR_SYSTEM_CLOCK_SELECT = 8'h97;
  // values after reset
  localparam logic [7:0] RESET_INTERNAL_OSC_CONTROL = 8'hC0;
  localparam logic [7:0] RESET_EXTERNAL_OSC_CONTROL = 8'h00;
  localparam logic [7:0] RESET_SYSTEM_CLOCK_SELECT = 8'h00;
  // default trim code, arbitrary stand-in for the factory value
  localparam logic [7:0] RESET_INTERNAL_OSC_TRIM = 8'h80;
  // field positions
  localparam int BIT_INTERNAL_OSC_ENABLE = 7;
  localparam int BIT_INTERNAL_OSC_READY = 6;
  localparam int BIT_CRYSTAL_VALID = 7;
  localparam int LSB_INTERNAL_DIVIDE_SEL = 0;
  localparam int LSB_CLOCK_SOURCE_SEL = 0;
  localparam int LSB_CLOCK_OUT_DIVIDE = 4;
  localparam int LSB_EXTERNAL_MODE_SEL = 4;
  localparam int LSB_EXTERNAL_FREQ_CTRL = 0;
  // clock rate and settle counts
  localparam int CORE_CLK_MHZ = 100;
  localparam int INT_OSC_SETTLE_NS = 40;
  localparam int INT_OSC_SETTLE_CYCLES = (INT_OSC_SETTLE_NS * CORE_CLK_MHZ + 999) / 1000;
  localparam int CRYSTAL_SETTLE_EDGES = 1024;
  localparam int SWITCH_TIMEOUT_CYCLES = 256;
  // software wait before polling crystal valid
  localparam int CRYSTAL_POLL_WAIT_MS = 1;
  localparam int CRYSTAL_POLL_WAIT_CYCLES = CRYSTAL_POLL_WAIT_MS * CORE_CLK_MHZ * 1000;

  // system clock sources
  typedef enum logic [1:0] {
    SRC_INTERNAL = 2'b00,
    SRC_EXTERNAL = 2'b01,
    SRC_PLL = 2'b10,
    SRC_RESERVED = 2'b11
  } clock_source_t;

  // external oscillator modes
  localparam logic [2:0] EXT_MODE_CMOS = 3'b010;
  localparam logic [2:0] EXT_MODE_CMOS_DIV2 = 3'b011;
  localparam logic [2:0] EXT_MODE_CRYSTAL = 3'b110;
  localparam logic [2:0] EXT_MODE_CRYSTAL_DIV2 = 3'b111;
endpackage : clock_select_pkg

// file: src/tick_divider.sv
`timescale 1ns/10ps
`default_nettype none
// passes every 2**ratio_log2-th input tick, ratio_log2 in 0..3
module tick_divider (
  input wire logic core_clk,
  input wire logic arst_n,
  input wire logic tick_in,
  input wire logic [1:0] ratio_log2,
  output logic tick_out
);
  logic [2:0] count; // free count of input ticks, wraps at 8
  logic [2:0] mask; // terminal count mask for the ratio

  // mask of the low count bits that must all be set
  always_comb begin
    unique case (ratio_log2)
      2'b00: mask = 3'h0;
      2'b01: mask = 3'h1;
      2'b10: mask = 3'h3;
      2'b11: mask = 3'h7;
    endcase
  end

  // pass at the masked terminal count; the free count is not realigned, so a ratio change can give one short period
  assign tick_out = tick_in && ((count & mask) == mask);

  // free count of input ticks
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      count <= 3'h0;
    end else if (tick_in) begin
      count <= count + 3'h1;
    end
  end
endmodule : tick_divider
`default_nettype wire

// file: verification/clock_select_monitor.sv
`timescale 1ns/10ps
`default_nettype none
// port checker for the clock source selector
module clock_select_monitor
  import clock_select_pkg::*;
(
  input wire logic core_clk,
  input wire logic arst_n,
  input wire logic [7:0] sfr_addr,
  input wire logic [7:0] sfr_wdata,
  input wire logic sfr_write,
  input wire logic sfr_read,
  input wire logic [7:0] sfr_rdata,
  input wire logic pll_locked,
  input wire logic internal_osc_enable,
  input wire logic [7:0] osc_trim,
  input wire logic [2:0] external_mode_sel,
  input wire logic external_tick,
  input wire logic [1:0] active_source
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!arst_n);
  // register port strobes by address
  sequence wr_ctl; sfr_write && sfr_addr == ADDR_INTERNAL_OSC_CONTROL; endsequence
  sequence wr_trim; sfr_write && sfr_addr == ADDR_INTERNAL_OSC_TRIM; endsequence
  sequence wr_ext; sfr_write && sfr_addr == ADDR_EXTERNAL_OSC_CONTROL; endsequence
  sequence rd_ext; sfr_read && sfr_addr == ADDR_EXTERNAL_OSC_CONTROL; endsequence
  sequence rd_sel; sfr_read && sfr_addr == ADDR_SYSTEM_CLOCK_SELECT; endsequence
  // external circuit held off for several cycles
  sequence ext_off; (external_mode_sel[2:1] == 2'b00) [*5]; endsequence
  AST_RESET_SRC: assert property ($rose(arst_n) |-> active_source == SRC_INTERNAL)
    else $error("source not internal after reset");
  AST_TRIM_WR: assert property (wr_trim |=> osc_trim == $past(sfr_wdata))
    else $error("trim write lost");
  AST_EN_WR: assert property (wr_ctl |=> internal_osc_enable == $past(sfr_wdata[7]))
    else $error("enable write lost");
  AST_MODE_WR: assert property (wr_ext |=> external_mode_sel == $past(sfr_wdata[6:4]))
    else $error("mode write lost");
  AST_EXT_BIT3: assert property (rd_ext |=> sfr_rdata[3] == 1'b0)
    else $error("reserved bit reads one");
  AST_PLL_FLAG: assert property (rd_sel |=> sfr_rdata[7] == $past(pll_locked))
    else $error("lock flag wrong");
  AST_SRC_LEGAL: assert property (active_source != SRC_RESERVED)
    else $error("reserved source active");
  AST_EXT_OFF: assert property (ext_off |-> !external_tick)
    else $error("tick while external off");
  AST_RD_HOLD: assert property (!sfr_read |=> $stable(sfr_rdata))
    else $error("read data moved");
endmodule : clock_select_monitor

bind system_clock_source_select clock_select_monitor clock_select_monitor_inst (
  .core_clk(core_clk), .arst_n(arst_n), .sfr_addr(sfr_addr), .sfr_wdata(sfr_wdata),
  .sfr_write(sfr_write), .sfr_read(sfr_read), .sfr_rdata(sfr_rdata),
  .pll_locked(pll_locked), .internal_osc_enable(internal_osc_enable),
  .osc_trim(osc_trim), .external_mode_sel(external_mode_sel),
  .external_tick(external_tick), .active_source(active_source)
);
`default_nettype wire

// file: verification/ext_osc_model.sv
`timescale 1ns/10ps
`default_nettype none
// external clock on the first crystal pin, free of the core clock phase
module ext_osc_model #(
  parameter int HALF_NS = 21
) (
  input wire logic run,
  output logic pin
);
  initial begin
    pin = 1'b0;
    forever begin
      #(HALF_NS);
      pin = run ? ~pin : 1'b0;
    end
  end
endmodule : ext_osc_model
`default_nettype wire

// file: verification/system_clock_source_select_tb.sv
`timescale 1ns/10ps
`default_nettype none
module system_clock_source_select_tb;
  import clock_select_pkg::*;
  logic core_clk, arst_n, sfr_write, sfr_read, pll_tick, pll_locked, ext_run, crystal_pin_a;
  logic [7:0] sfr_addr, sfr_wdata, sfr_rdata, osc_trim;
  logic [2:0] external_mode_sel, external_freq_ctrl;
  logic internal_osc_enable, system_clock, external_tick, clock_out_tick;
  logic [1:0] active_source;
  int err_total = 0;
  int checks = 0;
  int n, i;
  // ticks per 168 cycles for each external mode, 42 ns pin period
  int ext_cnt [8] = '{0, 0, 40, 20, 20, 20, 40, 20};
  system_clock_source_select #(.CRYSTAL_EDGES(4), .SWITCH_TIMEOUT(16))
    system_clock_source_select_inst (
    .core_clk(core_clk), .arst_n(arst_n), .sfr_addr(sfr_addr), .sfr_wdata(sfr_wdata),
    .sfr_write(sfr_write), .sfr_read(sfr_read), .sfr_rdata(sfr_rdata),
    .crystal_pin_a(crystal_pin_a), .pll_tick(pll_tick), .pll_locked(pll_locked),
    .internal_osc_enable(internal_osc_enable), .osc_trim(osc_trim),
    .external_mode_sel(external_mode_sel), .external_freq_ctrl(external_freq_ctrl),
    .system_clock(system_clock), .external_tick(external_tick),
    .clock_out_tick(clock_out_tick), .active_source(active_source)
  );
  ext_osc_model ext_osc_model_inst (.run(ext_run), .pin(crystal_pin_a));
  // core clock
  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end
  // pll pulses every other cycle
  always @(posedge core_clk) pll_tick <= ~pll_tick;
  task automatic complete_run;
    $display("checks %0d err_total %0d", checks, err_total);
    if (err_total == 0 && checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : complete_run
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp, input string what);
    checks++;
    if (seen !== exp) begin
      err_total++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  // one write strobe, then an idle edge
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    sfr_addr <= a;
    sfr_wdata <= d;
    sfr_write <= 1'b1;
    @(posedge core_clk);
    sfr_write <= 1'b0;
    @(posedge core_clk);
  endtask : wr
  task automatic get(input logic [7:0] a);
    sfr_addr <= a;
    sfr_read <= 1'b1;
    @(posedge core_clk);
    sfr_read <= 1'b0;
    @(posedge core_clk);
  endtask : get
  task automatic rd(input logic [7:0] a, input logic [7:0] e, input string what);
    get(a);
    chk(sfr_rdata, e, what);
  endtask : rd
  // counts pulses of system clock, clock out or external tick
  task automatic count(input int sel, input int cyc);
    n = 0;
    repeat (cyc) begin
      @(posedge core_clk);
      n += (sel == 0) ? system_clock : (sel == 1) ? clock_out_tick : external_tick;
    end
  endtask : count
  // a count within one of the expected figure, exact when zero
  function automatic logic [7:0] near(input int v, input int e);
    return 8'(v >= e - (e > 0) && v <= e + (e > 0));
  endfunction : near
  task automatic wait_src(input logic [1:0] s);
    for (i = 0; i < 64 && active_source !== s; i++) @(posedge core_clk);
    chk({6'h00, active_source}, {6'h00, s}, "source");
    if (i == 64) complete_run();
  endtask : wait_src
  initial begin
    arst_n = 1'b0; sfr_addr = 8'h00; sfr_wdata = 8'h00; sfr_write = 1'b0;
    sfr_read = 1'b0; pll_tick = 1'b0; pll_locked = 1'b0; ext_run = 1'b0;
    repeat (3) @(posedge core_clk);
    arst_n <= 1'b1;
    @(posedge core_clk);
    rd(8'h8A, RESET_INTERNAL_OSC_CONTROL, "int ctl");
    rd(8'h8B, RESET_INTERNAL_OSC_TRIM, "trim");
    rd(8'h8C, 8'h00, "ext ctl");
    rd(8'h97, 8'h00, "clk sel");
    wr(8'h8B, 8'h5A);
    rd(8'h8B, 8'h5A, "trim");
    for (int k = 0; k < 4; k++) begin
      wr(8'h8A, 8'h80 | 8'(k));
      count(0, 64);
      chk(8'(n), 8'(8 << k), "sys pulses");
    end
    wr(8'h8A, 8'h03);
    rd(8'h8A, 8'h03, "int off");
    wr(8'h8A, 8'h83);
    repeat (4) @(posedge core_clk);
    rd(8'h8A, 8'hC3, "int ready");
    count(0, 64);
    chk(8'(n), 8'd64, "sys pulses");
    for (int k = 0; k < 4; k++) begin
      wr(8'h97, 8'(k << 4));
      rd(8'h97, 8'(k << 4), "clk sel");
      count(1, 64);
      chk(8'(n), 8'(64 >> k), "out pulses");
    end
    ext_run <= 1'b1;
    for (int m = 0; m < 8; m++) begin
      wr(8'h8C, 8'((m << 4) | 6));
      repeat (8) @(posedge core_clk);
      count(2, 168);
      chk(near(n, ext_cnt[m]), 8'h01, "ext ticks");
    end
    wr(8'h8C, 8'h27);
    rd(8'h8C, 8'h27, "valid clear");
    wr(8'h8C, 8'h6F);
    rd(8'h8C, 8'h67, "ext ctl");
    chk({5'h00, external_freq_ctrl}, 8'h07, "freq ctrl");
    repeat (16) @(posedge core_clk);
    for (i = 0; i < 40 && sfr_rdata[7] !== 1'b1; i++) get(8'h8C);
    chk(sfr_rdata, 8'hE7, "crystal valid");
    if (i == 40) complete_run();
    wr(8'h97, 8'h01);
    wait_src(2'b01);
    count(0, 168);
    chk(near(n, 40), 8'h01, "ext sys");
    pll_locked <= 1'b1;
    wr(8'h97, 8'h02);
    wait_src(2'b10);
    rd(8'h97, 8'h82, "pll lock");
    count(0, 64);
    chk(8'(n), 8'd32, "pll sys");
    wr(8'h97, 8'h03);
    repeat (20) @(posedge core_clk);
    chk({6'h00, active_source}, 8'h02, "reserved src");
    wr(8'h97, 8'h00);
    wait_src(2'b00);
    wr(8'h8D, 8'hFF);
    rd(8'h8D, 8'h00, "unmapped");
    arst_n <= 1'b0;
    repeat (3) @(posedge core_clk);
    arst_n <= 1'b1;
    @(posedge core_clk);
    chk({6'h00, active_source}, 8'h00, "reset src");
    rd(8'h8B, RESET_INTERNAL_OSC_TRIM, "trim");
    complete_run();
  end
endmodule : system_clock_source_select_tb
`default_nettype wire
